// ---- hdl/nas_alu.sv ----
// execution datapath of the nibble alu with skip logic
`timescale 1ns/1ps
`include "nas_defines.svh"
// Notes on behaviour
// RQ1: load immediate into acc; consecutive load-immediates after the first are skipped
// RQ2: table read fetches rom at page p, address d[2:0]:acc; high nibble b, low acc
// RQ3: table read uses one stack level while running; avoid when stack full
// RQ4: add memory nibble to acc, carry unchanged
// RQ5: add memory nibble plus carry to acc, carry out to carry flag
// RQ6: add immediate to acc, carry unchanged, skip next when no overflow
// RQ7: acc becomes acc and memory nibble
// RQ8: acc becomes acc or memory nibble
// RQ9: set carry flag, nothing else changes
// RQ10: clear carry flag, nothing else changes
// RQ11: skip next when carry flag is zero
// RQ12: acc becomes its one's complement
// RQ13: rotate carry and acc right one bit through carry
// RQ14: set selected bit of memory nibble
// RQ15: clear selected bit of memory nibble
// RQ16: skip next when selected memory nibble bit is zero
// RQ17: skip next when acc equals memory nibble
// RQ18: skip next when acc equals immediate
// RQ19: skipped instruction changes nothing
module nas_alu
    import nas_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       instr_valid,
    input  wire nas_op_type instr_op,
    input  wire logic [3:0] instr_imm,
    input  wire logic [4:0] instr_page,
    input  wire logic [2:0] table_high_bits,
    input  wire logic [3:0] pointed_memory_nibble,
    input  wire logic       stack_full,
    input  wire logic [7:0] rom_data,
    output logic            rom_req,
    output logic      [4:0] rom_page,
    output logic      [6:0] rom_addr,
    output logic            stack_push,
    output logic            stack_pop,
    output logic            stack_overflow,
    output logic            busy,
    output logic            mem_write,
    output logic      [3:0] mem_wdata,
    output logic      [3:0] acc,
    output logic      [3:0] b_reg,
    output logic            carry_flag,
    output logic            skip_next
);
    nas_state_type state;
    nas_state_type next_state;
    logic          next_rom_req;
    logic    [4:0] next_rom_page;
    logic    [6:0] next_rom_addr;
    logic          next_stack_push;
    logic          next_stack_pop;
    logic          next_stack_overflow;
    logic          next_mem_write;
    logic    [3:0] next_mem_wdata;
    logic    [3:0] next_acc;
    logic    [3:0] next_b_reg;
    logic          next_carry_flag;
    logic          next_skip_next;
    logic          last_was_load;
    logic          next_last_was_load;
    logic    [4:0] sum;
    logic    [4:0] imm_sum;
    logic          next_busy;
    logic          exec_slot;
    logic          skip_slot;

    // one-hot mask of the memory bit picked by a two-bit index
    function automatic logic [3:0] bit_mask(input logic [1:0] idx);
        bit_mask = `NAS_BIT_ONE << idx;
    endfunction

    // 5-bit sum of two nibbles and a carry in
    function automatic logic [4:0] add_nib(input logic [3:0] x, input logic [3:0] y,
                                           input logic cin);
        add_nib = {1'b0, x} + {1'b0, y} + {4'h0, cin};
    endfunction

    // an instruction slot is open only while no table read is running
    function automatic logic slot_open(input logic valid, input nas_state_type st);
        slot_open = valid && (st == NAS_ST_RUN);
    endfunction

    // an open slot either executes or is eaten by a pending skip
    always_comb begin
        exec_slot = slot_open(instr_valid, state) && !skip_next;
        skip_slot = slot_open(instr_valid, state) && skip_next;
    end

    // table fetch control
    always_comb begin
        next_state          = state;
        next_rom_req        = `NAS_TAB_IDLE;
        next_rom_page       = rom_page;
        next_rom_addr       = rom_addr;
        next_stack_push     = 1'b0;
        next_stack_pop      = 1'b0;
        next_stack_overflow = 1'b0;
        unique case (state)
            NAS_ST_TABLE: begin
                // return from the table read frees the stack level again
                next_stack_pop = 1'b1; // RQ3
                next_state     = NAS_ST_RUN;
            end
            NAS_ST_RUN: begin
                if (exec_slot && (instr_op == NAS_OP_TABLE)) begin
                    next_rom_req        = 1'b1; // RQ2
                    next_rom_page       = instr_page; // RQ2
                    next_rom_addr       = {table_high_bits, acc}; // RQ2
                    next_stack_push     = 1'b1; // RQ3
                    // flagged only; the stack itself is kept outside this block
                    next_stack_overflow = stack_full; // RQ3
                    next_state          = NAS_ST_TABLE;
                end
            end
        endcase
        // busy follows the next state so the port comes straight from a flop
        next_busy = (next_state == NAS_ST_TABLE);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state          <= NAS_ST_RUN;
            rom_req        <= `NAS_TAB_IDLE;
            rom_page       <= `NAS_PAGE_RESET;
            rom_addr       <= `NAS_ADDR_RESET;
            stack_push     <= 1'b0;
            stack_pop      <= 1'b0;
            stack_overflow <= 1'b0;
            busy           <= 1'b0;
        end else begin
            state          <= next_state;
            rom_req        <= next_rom_req;
            rom_page       <= next_rom_page;
            rom_addr       <= next_rom_addr;
            stack_push     <= next_stack_push;
            stack_pop      <= next_stack_pop;
            stack_overflow <= next_stack_overflow;
            busy           <= next_busy;
        end
    end

    // skip flag and load-run tracking
    always_comb begin
        next_skip_next     = skip_next;
        next_last_was_load = last_was_load;
        imm_sum            = `NAS_SUM_ZERO;
        if (skip_slot) begin
            // a skipped slot still ends the skip; a skipped load keeps the load run alive
            next_skip_next     = 1'b0; // RQ19
            next_last_was_load = (instr_op == NAS_OP_LOAD_IMM) && last_was_load; // RQ1
        end else if (exec_slot) begin
            next_skip_next     = 1'b0;
            next_last_was_load = 1'b0;
            unique case (instr_op)
                NAS_OP_LOAD_IMM: begin
                    next_last_was_load = 1'b1; // RQ1
                end
                NAS_OP_ADD_IMM: begin
                    imm_sum        = add_nib(acc, instr_imm, 1'b0);
                    next_skip_next = ~imm_sum[4]; // RQ6
                end
                NAS_OP_TEST_CY: begin
                    next_skip_next = ~carry_flag; // RQ11
                end
                NAS_OP_BIT_TEST: begin
                    next_skip_next = (pointed_memory_nibble & bit_mask(instr_imm[1:0]))
                                     == `NAS_NIB_ZERO; // RQ16
                end
                NAS_OP_CMP_MEM: begin
                    next_skip_next = (acc == pointed_memory_nibble); // RQ17
                end
                NAS_OP_CMP_IMM: begin
                    next_skip_next = (acc == instr_imm); // RQ18
                end
                NAS_OP_NOP: begin
                    next_skip_next = 1'b0;
                end
                default: begin
                    next_skip_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            skip_next     <= 1'b0;
            last_was_load <= 1'b0;
        end else begin
            skip_next     <= next_skip_next;
            last_was_load <= next_last_was_load;
        end
    end

    // write port for the addressed memory nibble; the nibble itself is held outside
    always_comb begin
        next_mem_write = 1'b0;
        next_mem_wdata = mem_wdata;
        if (exec_slot) begin
            unique case (instr_op)
                NAS_OP_BIT_SET: begin
                    next_mem_write = 1'b1; // RQ14
                    next_mem_wdata = pointed_memory_nibble | bit_mask(instr_imm[1:0]); // RQ14
                end
                NAS_OP_BIT_CLR: begin
                    next_mem_write = 1'b1; // RQ15
                    next_mem_wdata = pointed_memory_nibble & ~bit_mask(instr_imm[1:0]); // RQ15
                end
                default: begin
                    next_mem_write = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mem_write <= 1'b0;
            mem_wdata <= `NAS_NIB_ZERO;
        end else begin
            mem_write <= next_mem_write;
            mem_wdata <= next_mem_wdata;
        end
    end

    // architectural registers
    always_comb begin
        next_acc        = acc;
        next_b_reg      = b_reg;
        next_carry_flag = carry_flag;
        sum             = `NAS_SUM_ZERO;
        if (state == NAS_ST_TABLE) begin
            // rom byte is taken in the same cycle that rom_req is high
            next_b_reg = rom_data[7:4]; // RQ2
            next_acc   = rom_data[3:0]; // RQ2
        end else if (exec_slot) begin
            unique case (instr_op)
                NAS_OP_LOAD_IMM: begin
                    // only the first of a run of loads takes effect
                    if (!last_was_load) begin
                        next_acc = instr_imm; // RQ1
                    end
                end
                NAS_OP_ADD_MEM: begin
                    // carry out is dropped on purpose
                    sum      = add_nib(acc, pointed_memory_nibble, 1'b0);
                    next_acc = sum[3:0]; // RQ4
                end
                NAS_OP_ADD_MEMC: begin
                    sum             = add_nib(acc, pointed_memory_nibble, carry_flag);
                    next_acc        = sum[3:0]; // RQ5
                    next_carry_flag = sum[4]; // RQ5
                end
                NAS_OP_ADD_IMM: begin
                    sum      = add_nib(acc, instr_imm, 1'b0);
                    next_acc = sum[3:0]; // RQ6
                end
                NAS_OP_AND_MEM: begin
                    next_acc = acc & pointed_memory_nibble; // RQ7
                end
                NAS_OP_OR_MEM: begin
                    next_acc = acc | pointed_memory_nibble; // RQ8
                end
                NAS_OP_SET_CY: begin
                    next_carry_flag = 1'b1; // RQ9
                end
                NAS_OP_CLR_CY: begin
                    next_carry_flag = 1'b0; // RQ10
                end
                NAS_OP_COMPL: begin
                    next_acc = acc ^ `NAS_NIB_ONES; // RQ12
                end
                NAS_OP_ROR: begin
                    next_acc        = {carry_flag, acc[3:1]}; // RQ13
                    next_carry_flag = acc[0]; // RQ13
                end
                NAS_OP_TABLE: begin
                    // fetch group owns the table read; data lands next cycle
                end
                NAS_OP_NOP: begin
                    next_acc = acc;
                end
                default: begin
                    // tests and compares leave these registers alone
                    next_acc = acc;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc        <= `NAS_ACC_RESET;
            b_reg      <= `NAS_B_RESET;
            carry_flag <= `NAS_CARRY_RESET;
        end else begin
            acc        <= next_acc;
            b_reg      <= next_b_reg;
            carry_flag <= next_carry_flag;
        end
    end
endmodule

// ---- shared/nas_defines.svh ----
// constants for the nibble alu and skip datapath
`ifndef NAS_DEFINES_SVH
`define NAS_DEFINES_SVH
`define NAS_ACC_RESET   4'h0
`define NAS_B_RESET     4'h0
`define NAS_CARRY_RESET 1'b0
`define NAS_NIB_ZERO    4'h0
`define NAS_NIB_ONES    4'hF
`define NAS_TAB_IDLE    1'b0
`define NAS_PAGE_RESET  5'h00
`define NAS_ADDR_RESET  7'h00
`define NAS_SUM_ZERO    5'h00
`define NAS_BIT_ONE     4'h1
`endif

// ---- shared/nas_pkg.sv ----
// types for the nibble alu and skip datapath
package nas_pkg;
    typedef enum logic [4:0] {
        NAS_OP_NOP      = 5'h00,
        NAS_OP_LOAD_IMM = 5'h01,
        NAS_OP_TABLE    = 5'h02,
        NAS_OP_ADD_MEM  = 5'h03,
        NAS_OP_ADD_MEMC = 5'h04,
        NAS_OP_ADD_IMM  = 5'h05,
        NAS_OP_AND_MEM  = 5'h06,
        NAS_OP_OR_MEM   = 5'h07,
        NAS_OP_SET_CY   = 5'h08,
        NAS_OP_CLR_CY   = 5'h09,
        NAS_OP_TEST_CY  = 5'h0A,
        NAS_OP_COMPL    = 5'h0B,
        NAS_OP_ROR      = 5'h0C,
        NAS_OP_BIT_SET  = 5'h0D,
        NAS_OP_BIT_CLR  = 5'h0E,
        NAS_OP_BIT_TEST = 5'h0F,
        NAS_OP_CMP_MEM  = 5'h10,
        NAS_OP_CMP_IMM  = 5'h11
    } nas_op_type;
    typedef enum logic [0:0] {
        NAS_ST_RUN   = 1'b0,
        NAS_ST_TABLE = 1'b1
    } nas_state_type;
endpackage

// ---- tb/nas_alu_props.sv ----
// concurrent checks on the ports of the nibble alu datapath
`timescale 1ns/1ps
module nas_alu_props
    import nas_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       instr_valid,
    input wire nas_op_type instr_op,
    input wire logic [3:0] instr_imm,
    input wire logic [4:0] instr_page,
    input wire logic [2:0] table_high_bits,
    input wire logic [3:0] pointed_memory_nibble,
    input wire logic       stack_full,
    input wire logic [7:0] rom_data,
    input wire logic       rom_req,
    input wire logic [4:0] rom_page,
    input wire logic [6:0] rom_addr,
    input wire logic       stack_push,
    input wire logic       stack_pop,
    input wire logic       stack_overflow,
    input wire logic       busy,
    input wire logic       mem_write,
    input wire logic [3:0] mem_wdata,
    input wire logic [3:0] acc,
    input wire logic [3:0] b_reg,
    input wire logic       carry_flag,
    input wire logic       skip_next
);
    logic       run;
    nas_op_type op;
    // executes for real: neither ignored while busy nor consumed by a skip
    assign run = instr_valid && !busy && !skip_next;
    assign op  = instr_op;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_load_run_kept: assert property (run && op == NAS_OP_LOAD_IMM ##1
        instr_valid && op == NAS_OP_LOAD_IMM |=> $stable(acc))
        else $error("second load of a run changed acc");
    a_table_fetch_req: assert property (run && op == NAS_OP_TABLE |=>
        rom_req && stack_push && busy && rom_addr == {$past(table_high_bits), $past(acc)}
        && rom_page == $past(instr_page) && stack_overflow == $past(stack_full))
        else $error("table fetch request wrong");
    a_table_load_data: assert property (rom_req |=>
        stack_pop && !busy && {b_reg, acc} == $past(rom_data))
        else $error("table data not loaded");
    a_add_with_carry: assert property (run && op == NAS_OP_ADD_MEMC |=>
        {carry_flag, acc} == $past(acc) + $past(pointed_memory_nibble) + $past(carry_flag))
        else $error("add with carry wrong");
    a_add_imm_skip: assert property (run && op == NAS_OP_ADD_IMM |=>
        {~skip_next, acc} == $past(acc) + $past(instr_imm) && $stable(carry_flag))
        else $error("add immediate result or skip wrong");
    a_carry_ops_only: assert property (run && (op == NAS_OP_SET_CY || op == NAS_OP_CLR_CY)
        |=> carry_flag == ($past(instr_op) == NAS_OP_SET_CY) && $stable(acc))
        else $error("carry set or clear wrong");
    a_test_carry_skip: assert property (run && op == NAS_OP_TEST_CY |=>
        skip_next == !$past(carry_flag))
        else $error("carry test skip wrong");
    a_bit_set_write: assert property (run && op == NAS_OP_BIT_SET |=> mem_write
        && mem_wdata == ($past(pointed_memory_nibble) | 4'h1 << ($past(instr_imm) & 4'h3)))
        else $error("bit set write wrong");
    a_skipped_inert: assert property (instr_valid && !busy && skip_next |=> !skip_next
        && !mem_write && !rom_req && $stable(acc) && $stable(carry_flag))
        else $error("skipped instruction changed state");
endmodule
bind nas_alu nas_alu_props u_nas_alu_props (.*);

// ---- tb/test_nibble_alu_skip_logic.sv ----
// self-checking bench for the nibble alu datapath with skip logic
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_nibble_alu_skip_logic
    import nas_pkg::*;
;
    typedef struct packed {nas_op_type op; logic [7:0] im; logic [11:0] ex;} nas_row_type;
    logic        core_clk, reset, instr_valid, stack_full, rom_req, stack_push, stack_pop;
    logic        stack_overflow, busy, mem_write, carry_flag, skip_next;
    nas_op_type  instr_op;
    logic [3:0]  instr_imm, pointed_memory_nibble, mem_wdata, acc, b_reg, ea;
    logic [4:0]  instr_page, rom_page;
    logic [2:0]  table_high_bits;
    logic [7:0]  rom_data;
    logic [6:0]  rom_addr;
    int          n_mismatch, n_compared, cycles;
    nas_row_type r;
    // ex holds acc, {0, carry, skip, mem_write}, written nibble
    nas_row_type rows [33] = '{
        '{NAS_OP_LOAD_IMM, 8'h90, 12'h900}, '{NAS_OP_LOAD_IMM, 8'h30, 12'h900},
        '{NAS_OP_NOP, 8'h00, 12'h900}, '{NAS_OP_SET_CY, 8'h00, 12'h940},
        '{NAS_OP_ADD_MEM, 8'h08, 12'h140}, '{NAS_OP_ADD_MEMC, 8'h0E, 12'h040},
        '{NAS_OP_ADD_MEMC, 8'h02, 12'h300}, '{NAS_OP_ADD_IMM, 8'h40, 12'h720},
        '{NAS_OP_SET_CY, 8'h00, 12'h700}, '{NAS_OP_ADD_IMM, 8'h90, 12'h000},
        '{NAS_OP_TEST_CY, 8'h00, 12'h020}, '{NAS_OP_COMPL, 8'h00, 12'h000},
        '{NAS_OP_COMPL, 8'h00, 12'hF00}, '{NAS_OP_SET_CY, 8'h00, 12'hF40},
        '{NAS_OP_TEST_CY, 8'h00, 12'hF40}, '{NAS_OP_AND_MEM, 8'h06, 12'h640},
        '{NAS_OP_OR_MEM, 8'h09, 12'hF40}, '{NAS_OP_CLR_CY, 8'h00, 12'hF00},
        '{NAS_OP_LOAD_IMM, 8'hA0, 12'hA00}, '{NAS_OP_ROR, 8'h00, 12'h500},
        '{NAS_OP_ROR, 8'h00, 12'h240}, '{NAS_OP_ROR, 8'h00, 12'h900},
        '{NAS_OP_BIT_SET, 8'h21, 12'h915}, '{NAS_OP_BIT_CLR, 8'h3F, 12'h917},
        '{NAS_OP_BIT_TEST, 8'h0E, 12'h920}, '{NAS_OP_BIT_SET, 8'h00, 12'h900},
        '{NAS_OP_BIT_TEST, 8'h38, 12'h900}, '{NAS_OP_CMP_MEM, 8'h09, 12'h920},
        '{NAS_OP_NOP, 8'h00, 12'h900}, '{NAS_OP_CMP_MEM, 8'h08, 12'h900},
        '{NAS_OP_CMP_IMM, 8'h90, 12'h920}, '{NAS_OP_NOP, 8'h00, 12'h900},
        '{NAS_OP_CMP_IMM, 8'h40, 12'h900}};
    nas_alu DUT (.core_clk, .reset, .instr_valid, .instr_op, .instr_imm, .instr_page,
        .table_high_bits, .pointed_memory_nibble, .stack_full, .rom_data, .rom_req,
        .rom_page, .rom_addr, .stack_push, .stack_pop, .stack_overflow, .busy,
        .mem_write, .mem_wdata, .acc, .b_reg, .carry_flag, .skip_next);
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    // the whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 400) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        {reset, instr_valid, stack_full, instr_imm, pointed_memory_nibble} = 11'h400;
        {instr_op, instr_page, table_high_bits} = '0;
        rom_data = 8'h58;
        repeat (5) @(negedge core_clk);
        reset = 0;
        `CHK({acc, b_reg, carry_flag, skip_next, busy, rom_req}, 12'h000)
        instr_valid = 1;
        for (int i = 0; i < 33; i++) begin
            r = rows[i];
            instr_op = r.op;
            {instr_imm, pointed_memory_nibble} = r.im;
            @(negedge core_clk);
            `CHK({acc, 1'b0, carry_flag, skip_next, mem_write}, r.ex[11:4])
            if (mem_write === 1'b1) `CHK(mem_wdata, r.ex[3:0])
        end
        $display("instruction rows done");
        ea = 4'h9;
        {table_high_bits, instr_page, instr_op} = {3'h5, 5'h13, NAS_OP_TABLE};
        for (int k = 0; k < 2; k++) begin
            instr_valid = 1;
            stack_full = (k == 0);
            @(negedge core_clk);
            instr_valid = 0;
            rom_data = 8'hA7;
            `CHK({rom_req, stack_push, busy, stack_overflow, rom_page, rom_addr}, {3'h7, k == 0, 5'h13, 3'h5, ea})
            @(negedge core_clk);
            // released rom bus shows the inverse of the last byte
            rom_data = 8'h58;
            `CHK({stack_pop, busy, b_reg, acc}, 10'h2A7)
            ea = 4'h7;
        end
        $display("table reads done");
        {instr_valid, instr_op} = {1'b1, NAS_OP_SET_CY};
        @(negedge core_clk);
        instr_valid = 0;
        `CHK(carry_flag, 1'b1)
        reset = 1;
        #1 `CHK({acc, b_reg, carry_flag, skip_next}, 10'h000)
        @(negedge core_clk);
        reset = 0;
        {instr_valid, instr_op, instr_imm} = {1'b1, NAS_OP_LOAD_IMM, 4'h6};
        @(negedge core_clk);
        instr_valid = 0;
        `CHK({acc, busy, skip_next}, 6'h18)
        $display("mid-run reset done");
        end_of_test();
    end
endmodule
